/* File: fackg_pkg.sv */
// Shared constants and types for the frame acknowledgement generator.
// Assumes one core clock; all users import the whole package.
package fackg_pkg;

    // ****************************************************************
    // Defaults
    // ****************************************************************
    localparam int SEQ_W_DEF = 6;
    localparam int GRP_DEF   = 4;
    localparam int ACK_ONE   = 1;

    // ****************************************************************
    // Engine states
    // ****************************************************************
    typedef enum logic [1:0] {
        FACKG_IDLE,
        FACKG_FLUSH,
        FACKG_EVAL
    } fackg_state_t;

endpackage : fackg_pkg

/* File: fackg_pfx_mem.sv */
// Small memory holding, per frame group, how many frames are already acknowledged.
// Assumes synchronous clear from the owner; read data is registered.
`timescale 1ns/100ps

module fackg_pfx_mem #(
    parameter int DEPTH  = 16,
    parameter int DATA_W = 3,
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              reset_n_i,
    // Control
    input  wire logic              clr_i,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [DATA_W-1:0] rd_data_o
);

    logic [DATA_W-1:0] mem_r   [DEPTH];
    logic [DATA_W-1:0] mem_nxt [DEPTH];
    logic [DATA_W-1:0] rd_nxt;

    always_comb
    begin
        mem_nxt = mem_r;
        if (clr_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_nxt[i] = '0;
            end
        end
        else if (wr_en_i)
        begin
            mem_nxt[wr_addr_i] = wr_data_i;
        end
        rd_nxt = mem_r[rd_addr_i];
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_r[i] <= '0;
            end
            rd_data_o <= '0;
        end
        else
        begin
            mem_r     <= mem_nxt;
            rd_data_o <= rd_nxt;
        end
    end

endmodule // fackg_pfx_mem

/* File: fackg_gen.sv */
// Acknowledgement generator for a sequence recipient: grouped or per-frame mode.
// Assumes frame events come from logic on core_clk_i, one per accepted cycle.
`timescale 1ns/100ps

// Operation
// [RL1] In-order complete group gives one ack: top count, group size, history zero.
// [RL2] Out-of-order group, once all lower frames present, still gets one clean ack.
// [RL3] Ack count equals frames covered, counted down from carried count; last may be short.
// [RL4] History set while a lower frame is missing; late frame gets count one (grouped mode: its ack also covers later frames already received in its group).
// [RL5] Single mode: one ack per frame, count one, own sequence count.
// [RL6] Keep received bitmap; derive lowest missing frame, count and history from it.
module fackg_gen
    import fackg_pkg::*;
#(
    parameter int SEQ_W = fackg_pkg::SEQ_W_DEF,
    parameter int GRP   = fackg_pkg::GRP_DEF
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    // Control
    input  wire logic             mode_single_i,
    input  wire logic             seq_start_i,
    // Received data frame events
    input  wire logic             frm_valid_i,
    input  wire logic [SEQ_W-1:0] frm_seq_cnt_i,
    input  wire logic             frm_last_i,
    output logic                  frm_ready_o,
    // Acknowledgement out
    output logic                  ack_valid_o,
    output logic [SEQ_W-1:0]      ack_seq_o,
    output logic [$clog2(GRP+1)-1:0] ack_cnt_o,
    output logic                  ack_hist_o
);
    import fackg_pkg::*;

    localparam int NSEQ = 1 << SEQ_W;
    localparam int OW   = $clog2(GRP);
    localparam int GW   = SEQ_W - OW;
    localparam int NGRP = NSEQ / GRP;
    localparam int CW   = $clog2(GRP+1);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Returns {complete, run length from prefix upward}
    function automatic logic [CW:0] run_calc(input logic [GRP-1:0] bits,
                                             input logic [CW-1:0]  pfx,
                                             input logic [OW-1:0]  lim);
        logic [CW-1:0] cnt;
        logic          cmp;
        logic          run;
        cnt = '0;
        cmp = 1'b1;
        run = 1'b1;
        for (int i = 0; i < GRP; i++)
        begin
            if (i <= int'(lim))
            begin
                if (!bits[i])
                    cmp = 1'b0;
                if (i >= int'(pfx))
                begin
                    if (bits[i] && run)
                        cnt = CW'(cnt + 1'b1);
                    else
                        run = 1'b0;
                end
            end
        end
        return {cmp, cnt};
    endfunction

    // Lowest sequence count not yet received; NSEQ when none
    function automatic logic [SEQ_W:0] lowest_missing(input logic [NSEQ-1:0] v);
        logic [SEQ_W:0] res;
        res = (SEQ_W+1)'(NSEQ);
        for (int i = NSEQ - 1; i >= 0; i--)
        begin
            if (!v[i])
                res = (SEQ_W+1)'(i);
        end
        return res;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    fackg_state_t     state_r,   state_nxt;
    logic [NSEQ-1:0]  recv_r,    recv_nxt;
    logic [SEQ_W-1:0] fs_r,      fs_nxt;
    logic [SEQ_W-1:0] end_r,     end_nxt;
    logic             end_vld_r, end_vld_nxt;
    logic [GW-1:0]    cur_grp_r, cur_grp_nxt;
    logic             rdy_r,     rdy_nxt;
    logic             ackv_r,    ackv_nxt;
    logic [SEQ_W-1:0] aseq_r,    aseq_nxt;
    logic [CW-1:0]    acnt_r,    acnt_nxt;
    logic             ahist_r,   ahist_nxt;

    logic [GW-1:0]    rd_addr;
    logic [CW-1:0]    pfx_rd;
    logic             pfx_we;
    logic [CW-1:0]    pfx_wd;
    logic             pfx_clr;
    logic [GW-1:0]    k_sel;
    logic [SEQ_W-1:0] k_base;
    logic [OW-1:0]    k_lim;
    logic [CW:0]      res;
    logic [SEQ_W-1:0] run_bot;
    logic [SEQ_W:0]   lo;

    fackg_pfx_mem #(
        .DEPTH  (NGRP),
        .DATA_W (CW),
        .ADDR_W (GW)
    ) u_pfx_mem (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .clr_i      (pfx_clr),
        .wr_en_i    (pfx_we),
        .wr_addr_i  (k_sel),
        .wr_data_i  (pfx_wd),
        .rd_addr_i  (rd_addr),
        .rd_data_o  (pfx_rd)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        state_nxt   = state_r;
        recv_nxt    = recv_r;
        fs_nxt      = fs_r;
        end_nxt     = end_r;
        end_vld_nxt = end_vld_r;
        cur_grp_nxt = cur_grp_r;
        ackv_nxt    = 1'b0;
        aseq_nxt    = aseq_r;
        acnt_nxt    = acnt_r;
        ahist_nxt   = ahist_r;
        rd_addr     = cur_grp_r;
        pfx_we      = 1'b0;
        pfx_clr     = 1'b0;
        lo          = lowest_missing(recv_r);                            // see [RL6]
        k_sel       = (state_r == FACKG_FLUSH) ? cur_grp_r : fs_r[SEQ_W-1:OW];
        k_base      = {k_sel, {OW{1'b0}}};
        k_lim       = (end_vld_r && end_r[SEQ_W-1:OW] == k_sel) ? end_r[OW-1:0] : '1;
        res         = run_calc(recv_r[k_base +: GRP], pfx_rd, k_lim);
        run_bot     = SEQ_W'(k_base + SEQ_W'(pfx_rd));
        pfx_wd      = CW'(pfx_rd + res[CW-1:0]);
        unique case (state_r)
            FACKG_IDLE:
            begin
                if (seq_start_i)
                begin
                    recv_nxt    = '0;
                    end_vld_nxt = 1'b0;
                    cur_grp_nxt = '0;
                    pfx_clr     = 1'b1;
                end
                else if (frm_valid_i)
                begin
                    recv_nxt[frm_seq_cnt_i] = 1'b1;                      // see [RL6]
                    fs_nxt = frm_seq_cnt_i;
                    if (frm_last_i)
                    begin
                        end_nxt     = frm_seq_cnt_i;
                        end_vld_nxt = 1'b1;
                    end
                    if (mode_single_i)
                    begin
                        ackv_nxt  = 1'b1;                                // see [RL5]
                        aseq_nxt  = frm_seq_cnt_i;
                        acnt_nxt  = CW'(ACK_ONE);
                        ahist_nxt = lo < {1'b0, frm_seq_cnt_i};          // see [RL4]
                    end
                    else if (frm_seq_cnt_i[SEQ_W-1:OW] != cur_grp_r)
                    begin
                        state_nxt = FACKG_FLUSH;
                    end
                    else
                    begin
                        rd_addr   = frm_seq_cnt_i[SEQ_W-1:OW];
                        state_nxt = FACKG_EVAL;
                    end
                end
            end
            FACKG_FLUSH, FACKG_EVAL:
            begin
                // Flush sends a partial run; eval waits for a group complete up to k_lim
                if (res[CW-1:0] != '0 && (state_r == FACKG_FLUSH || res[CW]))
                begin
                    ackv_nxt  = 1'b1;                                    // see [RL1]
                    aseq_nxt  = SEQ_W'(run_bot + SEQ_W'(res[CW-1:0]) - 1'b1); // see [RL3]
                    acnt_nxt  = res[CW-1:0];                             // see [RL3]
                    ahist_nxt = lo < {1'b0, run_bot};                    // see [RL2]
                    pfx_we    = 1'b1;
                end
                if (state_r == FACKG_FLUSH)
                begin
                    rd_addr   = fs_r[SEQ_W-1:OW];
                    state_nxt = FACKG_EVAL;
                end
                else
                begin
                    cur_grp_nxt = k_sel;
                    state_nxt   = FACKG_IDLE;
                end
            end
        endcase
        rdy_nxt = (state_nxt == FACKG_IDLE);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r   <= FACKG_IDLE;
            recv_r    <= '0;
            fs_r      <= '0;
            end_r     <= '0;
            end_vld_r <= 1'b0;
            cur_grp_r <= '0;
            rdy_r     <= 1'b1;
            ackv_r    <= 1'b0;
            aseq_r    <= '0;
            acnt_r    <= '0;
            ahist_r   <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            recv_r    <= recv_nxt;
            fs_r      <= fs_nxt;
            end_r     <= end_nxt;
            end_vld_r <= end_vld_nxt;
            cur_grp_r <= cur_grp_nxt;
            rdy_r     <= rdy_nxt;
            ackv_r    <= ackv_nxt;
            aseq_r    <= aseq_nxt;
            acnt_r    <= acnt_nxt;
            ahist_r   <= ahist_nxt;
        end
    end

    assign frm_ready_o = rdy_r;
    assign ack_valid_o = ackv_r;
    assign ack_seq_o   = aseq_r;
    assign ack_cnt_o   = acnt_r;
    assign ack_hist_o  = ahist_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [SEQ_W-1:0] chk_bot;
    logic [SEQ_W:0]   chk_lo;
    logic             chk_cov;
    always_comb
    begin
        chk_bot = SEQ_W'(ack_seq_o - SEQ_W'(ack_cnt_o) + 1'b1);
        chk_lo  = lowest_missing(recv_r);
        chk_cov = 1'b1;
        for (int i = 0; i < GRP; i++)
        begin
            if (i < int'(ack_cnt_o) && !recv_r[SEQ_W'(chk_bot + SEQ_W'(i))])
                chk_cov = 1'b0;
        end
    end

    chk_single_ack: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see [RL5]
        (frm_ready_o && frm_valid_i && !seq_start_i && mode_single_i)
        |=> (ack_valid_o && ack_cnt_o == CW'(ACK_ONE) && ack_seq_o == $past(frm_seq_cnt_i)))
        else $error("single mode ack missing or wrong");
    chk_count_range: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see [RL3]
        ack_valid_o |-> (ack_cnt_o != '0 && int'(ack_cnt_o) <= GRP))
        else $error("ack count out of range");
    chk_cover_recv: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see [RL6]
        ack_valid_o |-> chk_cov)
        else $error("ack covers a frame not received");
    chk_hist_value: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see [RL4]
        ack_valid_o |-> (ack_hist_o == (chk_lo < {1'b0, chk_bot})))
        else $error("history flag disagrees with bitmap");
    chk_group_done: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see [RL2]
        (frm_ready_o && frm_valid_i && !seq_start_i && !mode_single_i)
        |=> !frm_ready_o ##[1:2] frm_ready_o)
        else $error("grouped evaluation did not finish");
    chk_full_group: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // see [RL1]
        (state_r == FACKG_EVAL && res[CW] && pfx_rd == '0 && k_lim == '1)
        |=> (ack_valid_o && int'(ack_cnt_o) == GRP && ack_seq_o[OW-1:0] == '1))
        else $error("complete group not acknowledged whole");

endmodule // fackg_gen

/* File: fackg_init_model.sv */
// Sequence initiator model: sends data frames to the acknowledgement generator.
// Assumes the bench calls send() in the time step of a rising clock edge.
`timescale 1ns/100ps

module fackg_init_model
#(
    parameter int SEQ_W = 6
) (
    // Clock
    input  wire logic             core_clk_i,
    // Frame handshake
    input  wire logic             frm_ready_i,
    output logic                  frm_valid_o,
    output logic [SEQ_W-1:0]      frm_seq_cnt_o,
    output logic                  frm_last_o
);

    initial
    begin
        frm_valid_o   = 1'b0;
        frm_seq_cnt_o = '0;
        frm_last_o    = 1'b0;
    end

    // ****************************************************************
    // Frame transfer
    // ****************************************************************
    // Holds the frame until an edge samples ready high
    task automatic send(input int s, input bit l);
        frm_valid_o   <= 1'b1;
        frm_seq_cnt_o <= s[SEQ_W-1:0];
        frm_last_o    <= l;
        do
            @(posedge core_clk_i);
        while (frm_ready_i !== 1'b1);
    endtask

    // Released count and last lines show the inverse of their last values
    task automatic release_bus();
        frm_valid_o   <= 1'b0;
        frm_seq_cnt_o <= ~frm_seq_cnt_o;
        frm_last_o    <= ~frm_last_o;
    endtask

endmodule // fackg_init_model

/* File: testbench.sv */
// Self-checking bench for the frame acknowledgement generator.
// Assumes the initiator model drives frames; a queue model predicts every ack.
`timescale 1ns/100ps

module testbench;
    import fackg_pkg::*;

    localparam int NS = 2**SEQ_W_DEF;

    logic                      core_clk_i = 1'b0;
    logic                      reset_n_i  = 1'b0;
    logic                      mode_single_i = 1'b0;
    logic                      seq_start_i   = 1'b0;
    logic                      frm_valid_i;
    logic [SEQ_W_DEF-1:0]      frm_seq_cnt_i;
    logic                      frm_last_i;
    logic                      frm_ready_o;
    logic                      ack_valid_o;
    logic [SEQ_W_DEF-1:0]      ack_seq_o;
    logic [$clog2(GRP_DEF+1)-1:0] ack_cnt_o;
    logic                      ack_hist_o;
    int                        failures = 0;
    int                        compares = 0;
    int                        seed     = 78;
    bit                        rx [NS];
    int                        pfx [NS/GRP_DEF];
    int                        end_s;
    int                        last_g;
    int                        eq [$];
    int                        ord [$];

    always #2 core_clk_i = ~core_clk_i;

    fackg_gen #(.SEQ_W(SEQ_W_DEF), .GRP(GRP_DEF)) i_fackg_gen (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .mode_single_i(mode_single_i),
        .seq_start_i(seq_start_i), .frm_valid_i(frm_valid_i),
        .frm_seq_cnt_i(frm_seq_cnt_i), .frm_last_i(frm_last_i),
        .frm_ready_o(frm_ready_o), .ack_valid_o(ack_valid_o), .ack_seq_o(ack_seq_o),
        .ack_cnt_o(ack_cnt_o), .ack_hist_o(ack_hist_o));

    fackg_init_model #(.SEQ_W(SEQ_W_DEF)) i_fackg_init_model (
        .core_clk_i(core_clk_i), .frm_ready_i(frm_ready_o), .frm_valid_o(frm_valid_i),
        .frm_seq_cnt_o(frm_seq_cnt_i), .frm_last_o(frm_last_i));

    // ****************************************************************
    // Reference model
    // ****************************************************************
    function automatic void clr_model();
        foreach (rx[i]) rx[i] = 1'b0;
        foreach (pfx[i]) pfx[i] = 0;
        end_s  = -1;
        last_g = -1;
        eq.delete();
    endfunction

    function automatic void push_ack(int top, int cnt);
        bit h = 1'b0;
        for (int i = 0; i < top - cnt + 1; i++) if (!rx[i]) h = 1'b1;
        eq.push_back(top * 16 + cnt * 2 + h);
    endfunction

    function automatic int lim(int g);
        return (end_s >= g * GRP_DEF && end_s < g * GRP_DEF + GRP_DEF) ?
            end_s - g * GRP_DEF + 1 : GRP_DEF;
    endfunction

    function automatic void flush(int g);
        int n = 0;
        while (pfx[g] + n < lim(g) && rx[g * GRP_DEF + pfx[g] + n]) n++;
        if (n > 0) push_ack(g * GRP_DEF + pfx[g] + n - 1, n);
        pfx[g] += n;
    endfunction

    function automatic void take(int s, bit l, bit single);
        int g = s / GRP_DEF;
        bit full = 1'b1;
        if (single)
        begin
            rx[s] = 1'b1;
            push_ack(s, 1);
            return;
        end
        if (last_g >= 0 && g != last_g) flush(last_g);
        rx[s] = 1'b1;
        if (l) end_s = s;
        for (int i = 0; i < lim(g); i++) if (!rx[g * GRP_DEF + i]) full = 1'b0;
        if (full) flush(g);
        last_g = g;
    endfunction

    // ****************************************************************
    // Checks and monitor
    // ****************************************************************
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
            clr_model();
        else
        begin
            if (ack_valid_o === 1'b1)
                chk({ack_seq_o, ack_cnt_o, ack_hist_o},
                    (eq.size() > 0) ? eq.pop_front() : 10'h3ff);
            if (frm_valid_i && frm_ready_o && !seq_start_i)
                take(frm_seq_cnt_i, frm_last_i, mode_single_i);
            if (seq_start_i && frm_ready_o)
                clr_model();
        end
    end

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    task automatic run_seq(input bit single);
        int mx = 0;
        foreach (ord[i]) if (ord[i] > mx) mx = ord[i];
        mode_single_i <= single;
        foreach (ord[i]) i_fackg_init_model.send(ord[i], ord[i] == mx);
        i_fackg_init_model.release_bus();
        repeat (8) @(posedge core_clk_i);
        chk(eq.size(), 10'h000);
        seq_start_i <= 1'b1;
        @(posedge core_clk_i);
        seq_start_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic base_list(input int n);
        ord.delete();
        for (int i = 0; i < n; i++) ord.push_back(i);
    endtask

    task automatic wrap_up();
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #(4 * 40000);
        failures++;
        wrap_up();
    end

    initial
    begin
        int n;
        int j;
        int t;
        repeat (20) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        base_list(14);
        run_seq(1'b0);
        ord[4] = 5;
        ord[5] = 4;
        run_seq(1'b0);
        base_list(14);
        ord.delete(3);
        ord.push_back(3);
        run_seq(1'b0);
        run_seq(1'b1);
        reset_n_i <= 1'b0;
        #1;
        chk({frm_ready_o, ack_valid_o}, 10'h002);
        repeat (3) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        for (int k = 0; k < 6; k++)
        begin
            n = 5 + {$random(seed)} % 20;
            base_list(n);
            for (int i = 0; i < n; i++)
            begin
                j = i - i % GRP_DEF + {$random(seed)} % GRP_DEF;
                if (j >= n) j = n - 1;
                t = ord[i];
                ord[i] = ord[j];
                ord[j] = t;
            end
            run_seq(1'($random(seed) & 1));
        end
        wrap_up();
    end

endmodule // testbench
